// File: core/flash_pin_sync.sv
// Two-flop synchroniser for the device data bus and ready/busy line.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
module flash_pin_sync
(
    // Clock and control
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Raw and synchronised pins
    input  wire logic [16:0] raw_i,
    output logic [16:0]      sync_o
);
    logic [16:0] meta_reg;

    // Two stages per bit
    genvar i;
    generate
        for (i = 0; i < 17; i = i + 1)
        begin : g_bit
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    meta_reg[i] <= 1'b1;
                    sync_o[i]   <= 1'b1;
                end
                else if (ce)
                begin
                    meta_reg[i] <= raw_i[i];
                    sync_o[i]   <= meta_reg[i];
                end
            end
        end
    endgenerate
endmodule // flash_pin_sync

// File: core/flash_read_cycle.sv
// Drives one asynchronous device read cycle on the pins per request.
// Assumes data_bus_i is already synchronised by the caller.
`timescale 1ns/1ps
`include "flash_status_consts.svh"
module flash_read_cycle
    import flash_status_pkg::*;
(
    // Clock and control
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // Request side
    flash_read_if.slave     rd,
    // Device pins
    output logic [21:0]     addr_o,
    output logic            chip_en_n,
    output logic            out_en_n,
    input  wire logic [15:0] data_bus_i
);
    logic [3:0] cnt_reg;
    logic       act_reg;

    // Cycle timer: chip enable and output enable low from cycle start until the sample count
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_reg   <= 4'h0;
            act_reg   <= 1'b0;
            chip_en_n <= 1'b1;
            out_en_n  <= 1'b1;
            addr_o    <= 22'h00_0000;
        end
        else if (ce)
        begin
            if (!act_reg && rd.req)
            begin
                act_reg   <= 1'b1;
                cnt_reg   <= 4'h0;
                addr_o    <= rd.addr;
                chip_en_n <= 1'b0;
                out_en_n  <= 1'b0;
            end
            else if (act_reg)
            begin
                cnt_reg <= cnt_reg + 4'h1;
                if (cnt_reg == 4'(`RD_SAMPLE))
                begin
                    out_en_n  <= 1'b1; // Each cycle is one device read
                    chip_en_n <= 1'b1;
                end
                if (cnt_reg == 4'(`RD_CYCLES))
                    act_reg <= 1'b0;
            end
        end
    end

    // Latch data at sample point
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rd.data <= 16'h0000;
        else if (ce && act_reg && cnt_reg == 4'(`RD_SAMPLE))
            rd.data <= data_bus_i;
    end

    assign rd.ack = ce && act_reg && (cnt_reg == 4'(`RD_CYCLES));
endmodule // flash_read_cycle

// File: core/flash_read_if.sv
// Request and answer of one device read cycle between poller and pin driver.
// Assumes both ends run on one clock.
`timescale 1ns/1ps
interface flash_read_if;
    logic        req;
    logic [21:0] addr;
    logic        ack;
    logic [15:0] data;

    modport master
    (
        output req,
        output addr,
        input  ack,
        input  data
    );
    modport slave
    (
        input  req,
        input  addr,
        output ack,
        output data
    );
endinterface

// File: core/flash_status_consts.svh
// Constants for the flash status poller: offsets, fields and timing.
// Assumes inclusion by bare name from the package and design modules.
`ifndef FLASH_STATUS_CONSTS_SVH
`define FLASH_STATUS_CONSTS_SVH

// Register offsets of the controller's own command and status port
`define REG_CTRL        4'h0
`define REG_ADDR        4'h1
`define REG_DATA        4'h2
`define REG_STATUS      4'h3
`define REG_RESULT      4'h4

// Control register fields
`define CTRL_START_BIT  0
`define CTRL_MODE_BIT   1
`define CTRL_SUSP_BIT   2

// Status register fields
`define ST_BUSY_BIT     0
`define ST_DONE_BIT     1
`define ST_FAIL_BIT     2
`define ST_SUSP_BIT     3
`define ST_RB_BIT       4
`define ST_SECT_BIT     5

// Status bit positions on the device data bus
`define POLL_BIT        7
`define TOGGLE_BIT      6
`define TIMEOUT_BIT     5
`define SECTOR_BIT      2

// Device read cycle length in clocks
`define RD_CYCLES       4'hE
`define RD_SAMPLE       4'hC
`define RD_RECOVER      4'h3

// Settle time before the first status read, ns
`define SETTLE_NS       32'h0000_0064
`define CLK_NS          32'h0000_0005

`endif

// File: core/flash_status_pkg.sv
// Types for the flash status poller.
// Assumes flash_status_consts.svh is on the include path.
package flash_status_pkg;
    `include "flash_status_consts.svh"

    // Kind of operation being monitored
    typedef enum logic [0:0]
    {
        OP_PROGRAM = 1'b0,
        OP_ERASE   = 1'b1
    } op_kind_t;

    // Poller states
    typedef enum logic [2:0]
    {
        ST_IDLE    = 3'b000,
        ST_SETTLE  = 3'b001,
        ST_READ_A  = 3'b010,
        ST_READ_B  = 3'b011,
        ST_RECHECK = 3'b100,
        ST_FINAL   = 3'b101,
        ST_DONE    = 3'b110
    } poll_state_t;
endpackage

// File: core/flash_status_poller.sv
// Host-side poller for a flash program or erase: reads status bits.
// Assumes the command sequence was already written to the device.
//
// Behaviour
// - Host drives the program address when reading the polling bit.
// - Host addresses a sector chosen for erase for erase status.
// - Valid data only from reads after the one showing completion.
// - Reread polling bit after timeout flag is seen set.
// - Recheck toggle bit after timeout flag is seen high.
// - At least two consecutive reads compared for toggling.
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "flash_status_consts.svh"
module flash_status_poller
    import flash_status_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Software register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // Device pins
    output logic [21:0]      flash_addr,
    output logic             chip_en_n,
    output logic             out_en_n,
    output logic             write_en_n,
    input  wire logic [15:0] data_bus_i,
    output logic [15:0]      data_bus_o,
    output logic             data_bus_oe,
    input  wire logic        ready_busy_in
);
    import flash_status_pkg::*;

    localparam int SETTLE_CYC = (`SETTLE_NS + `CLK_NS - 1) / `CLK_NS;

    flash_read_if rd ();

    logic [16:0]  sync_pins;
    logic [15:0]  bus_sync;
    logic         rb_sync;
    poll_state_t  state_reg;
    op_kind_t     kind_reg;
    logic [21:0]  addr_reg;
    logic [15:0]  wdata_reg;
    logic         check_sect_reg;
    logic [15:0]  first_reg;
    logic [15:0]  result_reg;
    logic         busy_reg;
    logic         done_reg;
    logic         fail_reg;
    logic         susp_reg;
    logic         sect_tog_reg;
    logic         to_seen_reg;
    logic [7:0]   settle_reg;
    logic         req_reg;
    logic         toggling;
    logic         polled_done;

    // Pins from outside the clock domain
    flash_pin_sync u_sync
    (
        .clk    (clk),
        .rst_n  (rst_n),
        .ce     (ce),
        .raw_i  ({ready_busy_in, data_bus_i}),
        .sync_o (sync_pins)
    );
    assign bus_sync = sync_pins[15:0];
    assign rb_sync  = sync_pins[16];

    // Read cycle engine
    flash_read_cycle u_cycle
    (
        .clk        (clk),
        .rst_n      (rst_n),
        .ce         (ce),
        .rd         (rd.slave),
        .addr_o     (flash_addr),
        .chip_en_n  (chip_en_n),
        .out_en_n   (out_en_n),
        .data_bus_i (bus_sync)
    );

    // Poller only reads; never writes or drives the data bus
    assign write_en_n  = 1'b1;
    assign data_bus_o  = 16'h0000;
    assign data_bus_oe = 1'b0;

    assign rd.req  = req_reg;
    assign rd.addr = addr_reg;

    // Toggle compare between two consecutive reads
    assign toggling = first_reg[`TOGGLE_BIT]
                      != rd.data[`TOGGLE_BIT];

    // Polling bit shows true datum when done
    always_comb
    begin
        if (kind_reg == OP_PROGRAM)
            polled_done = rd.data[`POLL_BIT]
                          == wdata_reg[`POLL_BIT];
        else
            polled_done = rd.data[`POLL_BIT];
    end

    // Command registers written by software
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            addr_reg       <= 22'h00_0000;
            wdata_reg      <= 16'h0000;
            kind_reg       <= OP_PROGRAM;
            check_sect_reg <= 1'b0;
        end
        else if (ce && reg_wr && state_reg == ST_IDLE)
        begin
            case (reg_addr)
                `REG_ADDR:
                    addr_reg <= reg_wdata[21:0];
                `REG_DATA:
                    wdata_reg <= reg_wdata[15:0];
                `REG_CTRL:
                begin
                    kind_reg       <= op_kind_t'(reg_wdata[`CTRL_MODE_BIT]);
                    check_sect_reg <= reg_wdata[`CTRL_SUSP_BIT];
                end
                default:
                    ;
            endcase
        end
    end

    // Status poll sequencer
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg    <= ST_IDLE;
            req_reg      <= 1'b0;
            settle_reg   <= 8'h00;
            first_reg    <= 16'h0000;
            result_reg   <= 16'h0000;
            busy_reg     <= 1'b0;
            done_reg     <= 1'b0;
            fail_reg     <= 1'b0;
            susp_reg     <= 1'b0;
            sect_tog_reg <= 1'b0;
            to_seen_reg  <= 1'b0;
        end
        else if (ce)
        begin
            req_reg <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (reg_wr && reg_addr == `REG_CTRL
                        && reg_wdata[`CTRL_START_BIT])
                    begin
                        // Started after the final command strobe
                        state_reg   <= ST_SETTLE;
                        settle_reg  <= 8'(SETTLE_CYC);
                        busy_reg    <= 1'b1;
                        done_reg    <= 1'b0;
                        fail_reg    <= 1'b0;
                        susp_reg    <= 1'b0;
                        to_seen_reg <= 1'b0;
                    end
                end
                ST_SETTLE:
                begin
                    if (settle_reg == 8'h00)
                    begin
                        state_reg <= ST_READ_A;
                        req_reg   <= 1'b1;
                    end
                    else
                        settle_reg <= settle_reg - 8'h01;
                end
                ST_READ_A:
                begin
                    if (rd.ack)
                    begin
                        first_reg <= rd.data;
                        state_reg <= ST_READ_B;
                        req_reg   <= 1'b1;
                    end
                end
                ST_READ_B, ST_RECHECK:
                begin
                    if (rd.ack)
                    begin
                        sect_tog_reg <= first_reg[`SECTOR_BIT]
                                        != rd.data[`SECTOR_BIT];
                        if (!toggling || polled_done)
                        begin
                            // Completed, or erase suspended
                            susp_reg  <= (kind_reg == OP_ERASE) && rb_sync
                                         && check_sect_reg
                                         && first_reg[`SECTOR_BIT]
                                            != rd.data[`SECTOR_BIT];
                            state_reg <= ST_FINAL;
                            req_reg   <= 1'b1;
                        end
                        else if (state_reg == ST_RECHECK)
                        begin
                            // Still toggling after timeout: failure
                            fail_reg  <= 1'b1;
                            busy_reg  <= 1'b0;
                            state_reg <= ST_DONE;
                        end
                        else if (rd.data[`TIMEOUT_BIT])
                        begin
                            // Recheck once more; may stop as flag rises
                            to_seen_reg <= 1'b1;
                            first_reg   <= rd.data;
                            state_reg   <= ST_RECHECK;
                            req_reg     <= 1'b1;
                        end
                        else
                        begin
                            // Keep polling; covers protected-sector windows
                            first_reg <= rd.data;
                            req_reg   <= 1'b1;
                        end
                    end
                end
                ST_FINAL:
                begin
                    if (rd.ack)
                    begin
                        result_reg <= rd.data;
                        done_reg   <= 1'b1;
                        busy_reg   <= 1'b0;
                        state_reg  <= ST_DONE;
                    end
                end
                ST_DONE:
                    state_reg <= ST_IDLE;
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // Register read port, data one cycle later
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            reg_rdata <= 32'h0000_0000;
        else if (ce)
        begin
            reg_rdata <= 32'h0000_0000;
            if (reg_rd)
            begin
                case (reg_addr)
                    `REG_ADDR:
                        reg_rdata <= {10'h000, addr_reg};
                    `REG_DATA:
                        reg_rdata <= {16'h0000, wdata_reg};
                    `REG_STATUS:
                        reg_rdata <= {26'h000_0000, sect_tog_reg,
                                      rb_sync, susp_reg, fail_reg,
                                      done_reg, busy_reg};
                    `REG_RESULT:
                        reg_rdata <= {16'h0000, result_reg};
                    default:
                        reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // flash_status_poller

// File: test/flash_dev_model.sv
// Behavioural flash device answering status reads from the poller.
// Assumes the bench arms each operation with a start pulse.
`timescale 1ns/1ps
module flash_dev_model
(
    // Device pins
    input  wire logic        chip_en_n,
    input  wire logic        out_en_n,
    input  wire logic [21:0] addr,
    output logic [15:0]      data_out,
    output logic             rb_pull_low,
    // Operation setup
    input  wire logic        start,
    input  wire logic        erase,
    input  wire logic        susp,
    input  wire logic        tmo,
    input  wire logic [7:0]  nreads,
    input  wire logic [15:0] wdata,
    input  wire logic [21:0] op_addr,
    output logic             addr_ok
);
    int          left = 0;
    logic        tog = 1'b0;
    logic        sec = 1'b0;
    logic [15:0] arr;
    logic [15:0] last = 16'h0000;
    wire         rd_n = chip_en_n | out_en_n;

    initial data_out = 16'hFFFF;
    initial addr_ok = 1'b1;
    assign arr = erase ? 16'hFFFF : wdata;
    // Open drain: low while working, released in suspend
    assign rb_pull_low = !susp && (left > 0 || tmo);

    // Arm a new operation
    always @(posedge start)
    begin
        left = nreads;
        addr_ok = 1'b1;
    end

    // One read cycle: status while busy, array data after
    always @(negedge rd_n)
    begin
        if (addr != op_addr)
            addr_ok = 1'b0;
        if (susp)
        begin
            sec = ~sec;
            last = {8'h00, 1'b1, tog, 6'h00};
            last[2] = sec;
        end
        else if (left > 1 || tmo)
        begin
            if (left > 1)
                left--;
            tog = ~tog;
            sec = erase & ~sec;
            last = {8'h00, ~wdata[7], tog, tmo, 5'h00};
            if (erase)
                last[7] = 1'b0;
            last[2] = sec;
        end
        else if (left == 1)
        begin
            left = 0;
            tog = ~tog;
            last = {~arr[15:8], arr[7], tog, ~arr[5:0]};
        end
        else
            last = arr;
        data_out = last;
    end

    // Released bus shows no stale value
    always @(posedge rd_n)
        data_out = ~last;
endmodule // flash_dev_model

// File: test/flash_status_poller_asserts.sv
// Checker on the poller's ports: read cycles, poll address, bus use.
// Assumes it is bound onto flash_status_poller.
`timescale 1ns/1ps
`include "flash_status_consts.svh"
module flash_status_poller_asserts
(
    // Clock and control
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        ce,
    // Register port
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Device pins
    input wire logic [21:0] flash_addr,
    input wire logic        chip_en_n,
    input wire logic        out_en_n,
    input wire logic        write_en_n,
    input wire logic        data_bus_oe
);
    logic [21:0] addr_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Last poll address written by software
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            addr_reg <= 22'h00_0000;
        else if (ce && reg_wr && reg_addr == `REG_ADDR)
            addr_reg <= reg_wdata[21:0];
    end

    chk_settle_first: assert property (ce && reg_wr
        && reg_addr == `REG_CTRL && reg_wdata[0] |-> out_en_n[*8])
        else $error("read too soon after start");
    chk_never_drives: assert property (write_en_n && !data_bus_oe)
        else $error("poller drove the device");
    chk_read_hold: assert property ($fell(out_en_n)
        |-> (!out_en_n)[*8]) else $error("read strobe too short");
    chk_read_length: assert property ($fell(out_en_n)
        |-> ##13 out_en_n) else $error("read strobe length wrong");
    chk_read_gap: assert property ($rose(out_en_n)
        |-> out_en_n[*2]) else $error("reads not separated");
    chk_addr_held: assert property (!out_en_n && !$fell(out_en_n)
        |-> $stable(flash_addr)) else $error("address moved in read");
    chk_poll_addr: assert property (!out_en_n
        |-> flash_addr == addr_reg)
        else $error("status read at wrong address");
    chk_pins_paired: assert property (chip_en_n == out_en_n)
        else $error("enables not paired");
    chk_rdata_idle: assert property (!$past(reg_rd)
        |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside slot");
endmodule // flash_status_poller_asserts

bind flash_status_poller flash_status_poller_asserts i_chk
(
    .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flash_addr(flash_addr), .chip_en_n(chip_en_n),
    .out_en_n(out_en_n), .write_en_n(write_en_n), .data_bus_oe(data_bus_oe)
);

// File: test/flash_status_poller_tb.sv
// Self-checking bench for the poller against a behavioural flash model.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ps
`include "flash_status_consts.svh"
module flash_status_poller_tb;
    import flash_status_pkg::*;

    typedef struct packed
    {
        logic erase; logic susp; logic tmo; logic [7:0] nreads;
        logic [15:0] data; logic [5:0] exp; logic [5:0] mask; logic res;
    } row_t;

    localparam logic [21:0] OP_ADDR = 22'h12_3456;
    // Operations: status expected under mask, result checked or not
    row_t rows [7] = '{
        '{1'b0, 1'b0, 1'b0, 8'h03, 16'h5A3C, 6'h12, 6'h17, 1'b1},
        '{1'b0, 1'b0, 1'b0, 8'h01, 16'h00C3, 6'h12, 6'h17, 1'b1},
        '{1'b1, 1'b0, 1'b0, 8'h06, 16'h0000, 6'h12, 6'h17, 1'b1},
        '{1'b1, 1'b0, 1'b0, 8'h01, 16'h0000, 6'h12, 6'h17, 1'b1},
        '{1'b0, 1'b0, 1'b1, 8'h02, 16'h1234, 6'h04, 6'h15, 1'b0},
        '{1'b1, 1'b0, 1'b1, 8'h02, 16'h0000, 6'h04, 6'h15, 1'b0},
        '{1'b1, 1'b1, 1'b0, 8'h00, 16'h0000, 6'h18, 6'h1D, 1'b0}};

    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [21:0] flash_addr;
    logic chip_en_n, out_en_n, write_en_n, data_bus_oe, rb_low, m_ok;
    logic [15:0] data_bus_o, dev_data;
    logic m_start = 1'b0, m_erase = 1'b0, m_susp = 1'b0, m_tmo = 1'b0;
    logic [7:0]  m_nreads = 8'h00;
    logic [15:0] m_data = 16'h0000;
    logic [31:0] v;
    int err_count = 0, checks = 0;

    // Bus and pulled-up ready line resolution
    wire [15:0] data_bus_i = data_bus_oe ? data_bus_o : dev_data;
    wire ready_busy_in = !rb_low;

    flash_status_poller i_flash_status_poller
    (
        .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .flash_addr(flash_addr),
        .chip_en_n(chip_en_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
        .data_bus_i(data_bus_i), .data_bus_o(data_bus_o),
        .data_bus_oe(data_bus_oe), .ready_busy_in(ready_busy_in)
    );
    flash_dev_model i_flash_dev_model
    (
        .chip_en_n(chip_en_n), .out_en_n(out_en_n), .addr(flash_addr),
        .data_out(dev_data), .rb_pull_low(rb_low), .start(m_start),
        .erase(m_erase), .susp(m_susp), .tmo(m_tmo), .nreads(m_nreads),
        .wdata(m_data), .op_addr(OP_ADDR), .addr_ok(m_ok)
    );

    // 200 MHz clock
    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic stop_test();
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cmp(input string name, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Arm the model, command the poller, wait until it goes idle
    task automatic run_op(input row_t r);
        int n;
        @(posedge clk);
        {m_erase, m_susp, m_tmo, m_nreads, m_data} <= r[39:13];
        m_start <= 1'b1;
        @(posedge clk);
        m_start <= 1'b0;
        wr(`REG_ADDR, {10'h000, OP_ADDR});
        wr(`REG_DATA, {16'h0000, r.data});
        wr(`REG_CTRL, {29'h0000_0000, r.susp, r.erase, 1'b1});
        n = 0;
        do
        begin
            rd(`REG_STATUS, v);
            n++;
        end
        while (v[0] !== 1'b0 && n < 3000);
    endtask

    // Watchdog
    initial
    begin
        repeat (40000) @(posedge clk);
        err_count++;
        stop_test();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(`REG_STATUS, v);
        cmp("idle status", 32'h0000_0000, v & 32'h0000_0007);
        rd(4'hF, v);
        cmp("unmapped", 32'h0000_0000, v);
        foreach (rows[i])
        begin
            run_op(rows[i]);
            cmp("status", 32'(rows[i].exp),
                v & 32'(rows[i].mask));
            cmp("poll address", 32'h0000_0001, 32'(m_ok));
            rd(`REG_RESULT, v);
            if (rows[i].res)
                cmp("result", rows[i].erase ? 32'h0000_FFFF
                    : 32'(rows[i].data), v);
        end
        // Poll address and written datum read back as last set
        rd(`REG_ADDR, v);
        cmp("poll address reg", {10'h000, OP_ADDR}, v);
        rd(`REG_DATA, v);
        cmp("data reg", 32'h0000_0000, v);
        // Reset in the middle of a hung operation
        run_op(rows[4]);
        run_op(rows[4]);
        wr(`REG_CTRL, 32'h0000_0001);
        repeat (60) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(`REG_STATUS, v);
        cmp("status after reset", 32'h0000_0000, v & 32'h0000_0007);
        cmp("read strobe after reset", 32'h0000_0001, {31'h0, out_en_n});
        stop_test();
    end
endmodule // flash_status_poller_tb
